/* design/sdt_ctrl_top.sv */
// Control and status port between a serial video core and its transceiver PHY.
// Assumes tx and rx core logic run on mclk; PHY lock, completion and ready inputs are asynchronous.
`timescale 1ns/1ps
`include "sdt_params.svh"

module sdt_ctrl_top
	import sdt_pkg::*;
#(
	parameter bit DYN_SWITCH = 1'b0,
	parameter bit DUAL_LINK  = 1'b0,
	parameter bit NEW_FAMILY = 1'b0,
	parameter bit RATE_MODE  = 1'b1,
	parameter bit RX_ONLY    = 1'b0
)
(
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	input  wire logic                        refclk_choice,
	output logic                             refclk_sel,
	input  wire logic                        phy_pll0_lock,
	input  wire logic                        phy_pll1_lock,
	output logic                             tx_pll_locked,
	output logic                             tx_pll_locked_alt,
	input  wire logic [`SDT_TO_BUS_W-1:0]    mgr_reconf_to,
	input  wire logic [`SDT_TO_BUS_W-1:0]    mgr_reconf_to_linkb,
	output logic      [`SDT_TO_BUS_W-1:0]    reconf_bus_toward_phy,
	output logic      [`SDT_TO_BUS_W-1:0]    reconf_bus_toward_phy_linkb,
	input  wire logic [`SDT_FROM_BUS_W-1:0]  phy_reconf_from,
	input  wire logic [`SDT_FROM_BUS_W-1:0]  phy_reconf_from_linkb,
	output logic      [`SDT_FROM_BUS_W-1:0]  reconf_bus_from_phy,
	output logic      [`SDT_FROM_BUS_W-1:0]  reconf_bus_from_phy_linkb,
	input  wire logic                        rate_change,
	input  wire logic                        reconf_done_in,
	output logic                             rx_start_reconf,
	input  wire logic                        rx_ready_in,
	input  wire logic                        force_lock_ref,
	input  wire logic                        force_lock_data,
	output logic                             lock_to_ref,
	output logic                             lock_to_data
);

	logic [`SDT_NUM_IF-1:0] if_en_a;
	logic [`SDT_NUM_IF-1:0] if_en_b;
	logic                   pll0_sync;
	logic                   pll1_sync;
	logic                   done_sync;
	logic                   ready_sync;
	logic                   next_refclk_sel;
	logic                   next_locked;
	logic                   next_locked_alt;

	sdt_reconf_state_e      state;
	sdt_reconf_state_e      next_state;
	logic                   pending;
	logic                   next_pending;
	logic                   next_start;
	logic                   next_ltr;
	logic                   next_ltd;

	// Receiver instances use only the lower interface; link B exists only in dual link
	always_comb
	begin
		if_en_a    = {~RX_ONLY, `SDT_BIT_ON};
		if_en_b    = DUAL_LINK ? if_en_a : {`SDT_NUM_IF{`SDT_BIT_OFF}};
	end

	sdt_bus_reg #(
		.IF_W   (`SDT_TO_IF_W),
		.NUM_IF (`SDT_NUM_IF)
	) u_to_phy_a (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.if_enable (if_en_a),
		.bus_in    (mgr_reconf_to),
		.bus_out   (reconf_bus_toward_phy)
	);

	sdt_bus_reg #(
		.IF_W   (`SDT_TO_IF_W),
		.NUM_IF (`SDT_NUM_IF)
	) u_to_phy_b (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.if_enable (if_en_b),
		.bus_in    (mgr_reconf_to_linkb),
		.bus_out   (reconf_bus_toward_phy_linkb)
	);

	sdt_bus_reg #(
		.IF_W   (`SDT_FROM_IF_W),
		.NUM_IF (`SDT_NUM_IF)
	) u_from_phy_a (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.if_enable (if_en_a),
		.bus_in    (phy_reconf_from),
		.bus_out   (reconf_bus_from_phy)
	);

	sdt_bus_reg #(
		.IF_W   (`SDT_FROM_IF_W),
		.NUM_IF (`SDT_NUM_IF)
	) u_from_phy_b (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.if_enable (if_en_b),
		.bus_in    (phy_reconf_from_linkb),
		.bus_out   (reconf_bus_from_phy_linkb)
	);

	// PHY status arrives with no core clock relation
	sdt_sync3 u_sync_pll0 (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.async_in  (phy_pll0_lock),
		.level_out (pll0_sync)
	);

	sdt_sync3 u_sync_pll1 (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.async_in  (phy_pll1_lock),
		.level_out (pll1_sync)
	);

	sdt_sync3 u_sync_done (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.async_in  (reconf_done_in),
		.level_out (done_sync)
	);

	sdt_sync3 u_sync_ready (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.async_in  (rx_ready_in),
		.level_out (ready_sync)
	);

	// Transmit side: clock choice and synthesizer lock reporting
	always_comb
	begin
		next_refclk_sel = `SDT_REFCLK_PRI;
		if (DYN_SWITCH && refclk_choice)
		begin
			next_refclk_sel = `SDT_REFCLK_ALT;
		end
		next_locked     = pll0_sync;
		next_locked_alt = DYN_SWITCH ? pll1_sync : `SDT_BIT_OFF;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			refclk_sel        <= `SDT_REFCLK_PRI;
			tx_pll_locked     <= `SDT_BIT_OFF;
			tx_pll_locked_alt <= `SDT_BIT_OFF;
		end
		else
		begin
			refclk_sel        <= next_refclk_sel;
			tx_pll_locked     <= next_locked;
			tx_pll_locked_alt <= next_locked_alt;
		end
	end

	// Receive reconfiguration handshake.
	// Older families: wait for completion high, then for it to fall so a stale high is not
	// taken as the next completion. Newer families: completion high means busy, its fall ends it.
	always_comb
	begin
		next_state   = state;
		next_pending = pending;
		next_start   = rx_start_reconf;
		case (state)
			SDT_ST_IDLE:
			begin
				next_start = `SDT_BIT_OFF;
				if (RATE_MODE && (rate_change || pending))
				begin
					next_state   = SDT_ST_REQ;
					next_start   = `SDT_BIT_ON;
					next_pending = rate_change && pending ? `SDT_BIT_ON : `SDT_BIT_OFF;
				end
			end
			SDT_ST_REQ:
			begin
				if (done_sync)
				begin
					if (NEW_FAMILY)
					begin
						next_state = SDT_ST_BUSY;
					end
					else
					begin
						next_state = SDT_ST_SETTLE;
						next_start = `SDT_BIT_OFF;
					end
				end
			end
			SDT_ST_BUSY:
			begin
				if (!done_sync)
				begin
					next_state = SDT_ST_IDLE;
					next_start = `SDT_BIT_OFF;
				end
			end
			SDT_ST_SETTLE:
			begin
				next_start = `SDT_BIT_OFF;
				if (!done_sync)
				begin
					next_state = SDT_ST_IDLE;
				end
			end
			default:
			begin
				next_state = SDT_ST_IDLE;
				next_start = `SDT_BIT_OFF;
			end
		endcase
		// A rate change seen during a reconfiguration is kept for one more request
		if (rate_change && RATE_MODE && (state != SDT_ST_IDLE))
		begin
			next_pending = `SDT_BIT_ON;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state           <= SDT_ST_IDLE;
			pending         <= `SDT_BIT_OFF;
			rx_start_reconf <= `SDT_BIT_OFF;
		end
		else
		begin
			state           <= next_state;
			pending         <= next_pending;
			rx_start_reconf <= next_start;
		end
	end

	// Clock recovery lock mode, newer families only (both held low otherwise): reference lock is forced while the receiver is being
	// reconfigured or its PHY sequence is not complete, so the CDR never chases a dead stream.
	always_comb
	begin
		next_ltr = `SDT_BIT_OFF;
		next_ltd = `SDT_BIT_OFF;
		if (NEW_FAMILY)
		begin
			next_ltr = force_lock_ref || !ready_sync || (state != SDT_ST_IDLE);
			next_ltd = force_lock_data && !next_ltr;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lock_to_ref  <= `SDT_BIT_OFF;
			lock_to_data <= `SDT_BIT_OFF;
		end
		else
		begin
			lock_to_ref  <= next_ltr;
			lock_to_data <= next_ltd;
		end
	end

endmodule

/* design/sdt_params.svh */
// Named constants for the transceiver control port: bus widths, reset values, polarities.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SDT_PARAMS_SVH
`define SDT_PARAMS_SVH

`define SDT_TO_IF_W      70
`define SDT_FROM_IF_W    46
`define SDT_NUM_IF       2
`define SDT_TO_BUS_W     (`SDT_TO_IF_W * `SDT_NUM_IF)
`define SDT_FROM_BUS_W   (`SDT_FROM_IF_W * `SDT_NUM_IF)
`define SDT_REFCLK_PRI   1'b0
`define SDT_REFCLK_ALT   1'b1
`define SDT_BIT_OFF      1'b0
`define SDT_BIT_ON       1'b1
`define SDT_SYNC_RST     1'b0

`endif

/* design/sdt_pkg.sv */
// Types shared by the transceiver control port modules.
// Assumes sdt_params.svh is on the include path.
`include "sdt_params.svh"

package sdt_pkg;

	typedef enum logic [1:0]
	{
		SDT_ST_IDLE   = 2'b00,
		SDT_ST_REQ    = 2'b01,
		SDT_ST_BUSY   = 2'b10,
		SDT_ST_SETTLE = 2'b11
	} sdt_reconf_state_e;

	typedef logic [`SDT_TO_BUS_W-1:0]   sdt_to_bus_t;
	typedef logic [`SDT_FROM_BUS_W-1:0] sdt_from_bus_t;

endpackage

/* design/sdt_sync3.sv */
// Three-stage synchroniser with agreement filter for one asynchronous level.
// Assumes the input is a slow level from outside the mclk domain.
`timescale 1ns/1ps
`include "sdt_params.svh"

module sdt_sync3
	import sdt_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic async_in,
	output logic      level_out
);

	logic stage1;
	logic stage2;
	logic stage3;
	logic next_level;

	// The first stage feeds only the second; the filter looks at stages two and three
	always_comb
	begin
		next_level = level_out;
		if (stage2 == stage3)
		begin
			next_level = stage3;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage1    <= `SDT_SYNC_RST;
			stage2    <= `SDT_SYNC_RST;
			stage3    <= `SDT_SYNC_RST;
			level_out <= `SDT_SYNC_RST;
		end
		else
		begin
			stage1    <= async_in;
			stage2    <= stage1;
			stage3    <= stage2;
			level_out <= next_level;
		end
	end

endmodule

/* design/sdt_bus_reg.sv */
// Registered pass-through stage for one reconfiguration bus with per-interface enables.
// Assumes both ends of the bus are timed to mclk.
`timescale 1ns/1ps
`include "sdt_params.svh"

module sdt_bus_reg
	import sdt_pkg::*;
#(
	parameter int IF_W   = 1,
	parameter int NUM_IF = 1
)
(
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	input  wire logic [NUM_IF-1:0]      if_enable,
	input  wire logic [IF_W*NUM_IF-1:0] bus_in,
	output logic      [IF_W*NUM_IF-1:0] bus_out
);

	logic [IF_W*NUM_IF-1:0] next_bus;

	// Interfaces that do not exist in this configuration are held at zero
	always_comb
	begin
		next_bus = '0;
		for (int i = 0; i < NUM_IF; i++)
		begin
			if (if_enable[i])
			begin
				next_bus[i*IF_W +: IF_W] = bus_in[i*IF_W +: IF_W];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_out <= '0;
		end
		else
		begin
			bus_out <= next_bus;
		end
	end

endmodule

/* tb/sdt_ctrl_properties.sv */
// Port checker for sdt_ctrl_top, bound into every instance.
// Assumes one clock mclk and asynchronous active-low rst_b.
`timescale 1ns/1ps
`include "sdt_params.svh"

module sdt_ctrl_properties
	import sdt_pkg::*;
#(
	parameter bit DYN_SWITCH = 1'b0,
	parameter bit DUAL_LINK  = 1'b0,
	parameter bit NEW_FAMILY = 1'b0
)
(
	input wire logic                       mclk,
	input wire logic                       rst_b,
	input wire logic                       refclk_choice,
	input wire logic                       refclk_sel,
	input wire logic                       phy_pll0_lock,
	input wire logic                       tx_pll_locked,
	input wire logic [`SDT_TO_BUS_W-1:0]   mgr_reconf_to_linkb,
	input wire logic [`SDT_TO_BUS_W-1:0]   reconf_bus_toward_phy_linkb,
	input wire logic [`SDT_FROM_BUS_W-1:0] phy_reconf_from,
	input wire logic [`SDT_FROM_BUS_W-1:0] reconf_bus_from_phy,
	input wire logic                       rate_change,
	input wire logic                       reconf_done_in,
	input wire logic                       rx_start_reconf,
	input wire logic                       lock_to_ref,
	input wire logic                       lock_to_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_refsel_follow: assert property ($past(rst_b) |-> refclk_sel == (DYN_SWITCH & $past(refclk_choice)))
		else $error("refclk_sel does not follow the choice input");
	a_from_pass: assert property ($past(rst_b) |-> reconf_bus_from_phy == $past(phy_reconf_from))
		else $error("bus from phy not passed through");
	a_linkb_pass: assert property ($past(rst_b) |->
		reconf_bus_toward_phy_linkb == (DUAL_LINK ? $past(mgr_reconf_to_linkb) : '0))
		else $error("link b bus toward phy wrong");
	a_lock_sync: assert property ($rose(phy_pll0_lock) ##1 phy_pll0_lock[*5] |-> tx_pll_locked)
		else $error("pll lock not reported after sync delay");
	a_req_hold: assert property (!NEW_FAMILY && rx_start_reconf && !reconf_done_in |=> rx_start_reconf)
		else $error("request dropped before completion");
	a_req_drop: assert property (!NEW_FAMILY && rx_start_reconf && $rose(reconf_done_in) |-> ##[3:6] !rx_start_reconf)
		else $error("request not dropped after completion");
	a_busy_hold: assert property (NEW_FAMILY && rx_start_reconf && reconf_done_in |=> rx_start_reconf)
		else $error("request dropped while manager busy");
	a_busy_drop: assert property (NEW_FAMILY && rx_start_reconf && $fell(reconf_done_in) |-> ##[3:6] !rx_start_reconf)
		else $error("request not dropped after busy fell");
	a_req_rise: assert property (rate_change |-> ##[1:60] rx_start_reconf)
		else $error("rate change did not raise a request");
	// Newer families may re-raise a kept request one cycle after the drop
	a_req_gap: assert property (!NEW_FAMILY && $fell(rx_start_reconf) |=> !rx_start_reconf)
		else $error("request raised again at once");
	a_lock_mode_off: assert property (!NEW_FAMILY |-> !lock_to_ref && !lock_to_data)
		else $error("lock mode outputs active on older family");
endmodule

bind sdt_ctrl_top sdt_ctrl_properties #(.DYN_SWITCH(DYN_SWITCH), .DUAL_LINK(DUAL_LINK), .NEW_FAMILY(NEW_FAMILY))
	u_props (.*);

/* tb/sdt_mgr_model.sv */
// Reconfiguration manager model: status rises lag cycles after a request.
// Assumes the request is a level that stays up until status is seen.
`timescale 1ns/1ps

module sdt_mgr_model
#(
	parameter bit NEW_STYLE = 1'b0
)
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       start_req,
	input  wire logic [3:0] lag,
	output logic            done
);
	logic [4:0] cnt;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			done <= 1'b0;
			cnt  <= 5'h00;
		end
		else if (!start_req)
		begin
			done <= 1'b0;
			cnt  <= 5'h00;
		end
		else if (NEW_STYLE)
		begin
			// Busy for eight cycles, then low until the request drops
			if (cnt != 5'h1f)
				cnt <= cnt + 5'h01;
			done <= (cnt >= {1'b0, lag}) && (cnt < {1'b0, lag} + 5'h08);
		end
		else if (cnt == {1'b0, lag})
			done <= 1'b1;
		else
			cnt <= cnt + 5'h01;
	end
endmodule

/* tb/sdt_ctrl_top_tb.sv */
// Self-checking bench for sdt_ctrl_top with a manager model on the far side.
// Assumes design, checker and model are compiled first.
`timescale 1ns/1ps
`include "sdt_params.svh"

module sdt_ctrl_top_tb;
	import sdt_pkg::*;
	logic          mclk = 1'b0;
	logic          rst_b = 1'b0;
	logic          refclk_choice, phy_pll0_lock, phy_pll1_lock, rate_change, rx_ready_in, reconf_done_in;
	logic          force_lock_ref, force_lock_data, refclk_sel, tx_pll_locked, tx_pll_locked_alt;
	logic          rx_start_reconf, lock_to_ref, lock_to_data;
	logic          rx_start_reconf_nf, reconf_done_nf, lock_to_ref_nf, lock_to_data_nf;
	sdt_to_bus_t   mgr_reconf_to, mgr_reconf_to_linkb, reconf_bus_toward_phy, reconf_bus_toward_phy_linkb;
	sdt_from_bus_t phy_reconf_from, phy_reconf_from_linkb, reconf_bus_from_phy, reconf_bus_from_phy_linkb;
	logic [3:0]    lag = 4'h0;
	logic [31:0]   seed = 32'habb9c1de;
	int            mismatches = 0;
	int            checks_done = 0;

	always #5 mclk = ~mclk;

	sdt_ctrl_top #(.DYN_SWITCH(1'b1), .DUAL_LINK(1'b1)) uut (.*);
	sdt_mgr_model mgr (.mclk(mclk), .rst_b(rst_b), .start_req(rx_start_reconf), .lag(lag), .done(reconf_done_in));
	// Newer-family instance without switching or link B; shares the stimulus
	sdt_ctrl_top #(.NEW_FAMILY(1'b1)) uut_nf (
		.mclk                        (mclk),
		.rst_b                       (rst_b),
		.refclk_choice               (refclk_choice),
		.refclk_sel                  (),
		.phy_pll0_lock               (phy_pll0_lock),
		.phy_pll1_lock               (phy_pll1_lock),
		.tx_pll_locked               (),
		.tx_pll_locked_alt           (),
		.mgr_reconf_to               (mgr_reconf_to),
		.mgr_reconf_to_linkb         (mgr_reconf_to_linkb),
		.reconf_bus_toward_phy       (),
		.reconf_bus_toward_phy_linkb (),
		.phy_reconf_from             (phy_reconf_from),
		.phy_reconf_from_linkb       (phy_reconf_from_linkb),
		.reconf_bus_from_phy         (),
		.reconf_bus_from_phy_linkb   (),
		.rate_change                 (rate_change),
		.reconf_done_in              (reconf_done_nf),
		.rx_start_reconf             (rx_start_reconf_nf),
		.rx_ready_in                 (rx_ready_in),
		.force_lock_ref              (force_lock_ref),
		.force_lock_data             (force_lock_data),
		.lock_to_ref                 (lock_to_ref_nf),
		.lock_to_data                (lock_to_data_nf)
	);
	sdt_mgr_model #(.NEW_STYLE(1'b1)) mgr_nf (.mclk(mclk), .rst_b(rst_b), .start_req(rx_start_reconf_nf), .lag(lag),
		.done(reconf_done_nf));

	function automatic logic [159:0] rnd();
		repeat (5)
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return {5{seed}} ^ {seed, 128'h0};
	endfunction

	task automatic chk(input string nm, input logic [139:0] seen, input logic [139:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Polls one cycle at a time; a hang counts as a mismatch
	task automatic wait_req(input logic lvl, input bit nf);
		int n;
		n = 0;
		while ((nf ? rx_start_reconf_nf : rx_start_reconf) !== lvl && n < 60)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(nf ? "rx_start_reconf_nf" : "rx_start_reconf", nf ? rx_start_reconf_nf : rx_start_reconf, lvl);
		if ((nf ? rx_start_reconf_nf : rx_start_reconf) !== lvl)
			test_done();
	endtask

	task automatic pulse();
		rate_change = 1'b1;
		@(posedge mclk);
		#1;
		rate_change = 1'b0;
	endtask

	initial
	begin
		{refclk_choice, phy_pll0_lock, phy_pll1_lock, rate_change, rx_ready_in} = '0;
		{force_lock_ref, force_lock_data} = '0;
		mgr_reconf_to = '0;
		phy_reconf_from = '0;
		mgr_reconf_to_linkb = '1;
		phy_reconf_from_linkb = '1;
		repeat (5) @(posedge mclk);
		#1;
		chk("reset linkb", reconf_bus_toward_phy_linkb, '0);
		rst_b = 1'b1;
		rx_ready_in = 1'b1;
		for (int k = 0; k < 40; k++)
		begin
			@(posedge mclk);
			#1;
			chk("refclk_sel", refclk_sel, refclk_choice);
			chk("toward_phy", reconf_bus_toward_phy, mgr_reconf_to);
			chk("toward_linkb", reconf_bus_toward_phy_linkb, mgr_reconf_to_linkb);
			chk("from_phy", reconf_bus_from_phy, phy_reconf_from);
			chk("from_linkb", reconf_bus_from_phy_linkb, phy_reconf_from_linkb);
			chk("lock_to_ref", {lock_to_ref, lock_to_data}, 2'b00);
			// Ready needs a few cycles through its synchroniser before lock mode follows the forces
			if (k >= 5)
				chk("nf_lock_mode", {lock_to_ref_nf, lock_to_data_nf}, {force_lock_ref, force_lock_data & !force_lock_ref});
			{refclk_choice, force_lock_ref, force_lock_data} = 3'(rnd());
			mgr_reconf_to = 140'(rnd());
			mgr_reconf_to_linkb = 140'(rnd());
			phy_reconf_from = 92'(rnd());
			phy_reconf_from_linkb = 92'(rnd());
		end
		repeat (2)
		begin
			phy_pll0_lock = !phy_pll0_lock;
			phy_pll1_lock = !phy_pll0_lock;
			repeat (6) @(posedge mclk);
			#1;
			chk("tx_pll_locked", tx_pll_locked, phy_pll0_lock);
			chk("tx_pll_locked_alt", tx_pll_locked_alt, phy_pll1_lock);
		end
		// Fastest, slowest and a random manager answer
		for (int i = 0; i < 3; i++)
		begin
			lag = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'(rnd());
			pulse();
			wait_req(1'b1, 1'b0);
			wait_req(1'b1, 1'b1);
			wait_req(1'b0, 1'b0);
			wait_req(1'b0, 1'b1);
			repeat (12)
			begin
				@(posedge mclk);
				#1;
				chk("no new request", rx_start_reconf, 1'b0);
				chk("no new request nf", rx_start_reconf_nf, 1'b0);
			end
		end
		// A second rate change during a request is kept and served afterwards
		pulse();
		@(posedge mclk);
		#1;
		pulse();
		wait_req(1'b1, 1'b0);
		wait_req(1'b0, 1'b0);
		wait_req(1'b1, 1'b0);
		wait_req(1'b0, 1'b0);
		wait_req(1'b0, 1'b1);
		test_done();
	end
endmodule
